/* rtl/adc_ctrl_defs.svh */
// Offsets, field positions, reset values and timing counts of the block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// =====================================================================
// Register map (byte addresses on the plain register port)
`define ADDR_CONTROL        8'h00
`define ADDR_STATUS         8'h04
`define ADDR_IRQ_STATUS     8'h08
`define ADDR_IRQ_MASK       8'h0C

// =====================================================================
// Field positions
`define CTRL_SOFT_STANDBY   0
`define STAT_MODE_LSB       0
`define STAT_GEN_LSB        2
`define STAT_POWERED_DOWN   4
`define STAT_WAKE_BUSY      5
`define IRQ_OVER_RANGE      0
`define IRQ_WAKE_DONE       1
`define IRQ_STRAP_CHANGE    2
`define IRQ_WIDTH           3

// =====================================================================
// Reset values
`define CONTROL_RESET       1'h0
`define IRQ_MASK_RESET      3'h0

// =====================================================================
// Strap levels as seen by the pad comparators
`define STRAP_GROUND        2'h0
`define STRAP_HALF_SUPPLY   2'h1
`define SENSE_TO_REF_NODE   2'h0
`define SENSE_TO_GROUND     2'h1
`define SENSE_TO_DIVIDER    2'h2
`define SENSE_TO_SUPPLY     2'h3

// =====================================================================
// Output coding and timing
`define CODE_MIN            0
`define CODE_MAX            1023
`define PIPE_STAGES         3
`define CLOCK_MHZ           125
`define WAKE_TIME_MS        5
`define WAKE_CYCLES         (`WAKE_TIME_MS * 1000 * `CLOCK_MHZ)

`endif

/* rtl/adc_ctrl_pkg.sv */
// Types and the code clamp shared by the converter control files
package adc_ctrl_pkg;

    // =================================================================
    // Reference configurations selected by the mode strap
    typedef enum logic [1:0] {
        REF_FULL_EXT   = 2'h0,
        REF_DIFF       = 2'h1,
        REF_TOP_BOTTOM = 2'h2
    } ref_mode_t;

    // Onboard generator output level
    typedef enum logic [1:0] {
        GEN_1V      = 2'h0,
        GEN_2V      = 2'h1,
        GEN_DIVIDER = 2'h2,
        GEN_OFF     = 2'h3
    } gen_level_t;

    // Power state machine, one-hot
    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'h1,
        PWR_DOWN   = 3'h2,
        PWR_WAKE   = 3'h4
    } pwr_state_t;

    // Switch and buffer settings driven to the analog reference block
    typedef struct packed {
        logic       buffer_enable;
        logic       buffer_from_sense;
        logic       sense_force_join;
        logic       generator_enable;
        gen_level_t generator_level;
    } ref_ctrl_t;

    // One conversion result with its over-range flag
    typedef struct packed {
        logic [9:0] code;
        logic       over_range;
    } conv_word_t;

    // =================================================================
    // Clamp a signed level (LSB units above bottom full scale)
    function automatic conv_word_t convert(input logic signed [11:0] lvl);
        conv_word_t w;
        w = '{code: 10'h000, over_range: 1'b0};
        if (lvl < 12'sh000) begin
            w.over_range = 1'b1;
        end else if (lvl > 12'sh3FF) begin
            w.code       = 10'h3FF;
            w.over_range = 1'b1;
        end else begin
            w.code = lvl[9:0];
        end
        return w;
    endfunction

endpackage

/* rtl/adc_pipe.sv */
// Sampling and conversion pipeline with clamping
`timescale 1ns/100ps
module adc_pipe #(
    parameter int DEPTH = 3
) (
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    input  wire logic                     enable,
    input  wire logic signed [11:0]       analog_input,
    output adc_ctrl_pkg::conv_word_t      result
);

    adc_ctrl_pkg::conv_word_t stage_reg  [DEPTH];
    adc_ctrl_pkg::conv_word_t stage_next [DEPTH];

    // =================================================================
    // Shift; a stopped converter freezes every stage
    // [R3] [R4] [R15] clamped straight binary with flag
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            stage_next[i] = stage_reg[i];
        end
        if (enable) begin
            stage_next[0] = adc_ctrl_pkg::convert(analog_input);
            for (int i = 1; i < DEPTH; i++) begin
                stage_next[i] = stage_reg[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign result = stage_reg[DEPTH-1];

endmodule

/* rtl/adc_output_and_mode_control.sv */
// Output, reference mode and power control of the 10-bit converter
//
// Contract
// [R1] With the enable low, each 10-bit result is driven, bit 0 least.
// [R2] With the enable high, data and over-range flag float together.
// [R3] Results are unsigned binary from 0 to 1023 bottom to top.
// [R4] In top/bottom mode an input beyond the sense levels raises the flag.
// [R5] Standby high powers the converter down and stops conversion.
// [R6] The host treats results as invalid for about 5 ms after standby.
// [R7] The mode strap picks full external, differential or top/bottom.
// [R8] Only differential mode takes differential or center-span inputs.
// [R9] Full external mode powers the buffer off and joins sense to force.
// [R10] Differential mode runs the buffer from the reference node, opened.
// [R11] Top/bottom mode runs the buffer from the sense pins, opened.
// [R12] The sense strap sets the generator to 1 V, 2 V, divider or open.
// [R13] Sense strap at supply powers the onboard generator down.
// [R14] A sample appears on the outputs after the third following edge.
// [R15] Inputs past full scale clamp to 0 or 1023 and raise the flag.
// [R16] Data and flag change once per clock on the rising edge.
`timescale 1ns/100ps
`include "adc_ctrl_defs.svh"
module adc_output_and_mode_control #(
    parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic signed [11:0]    analog_input,
    input  wire logic [1:0]            mode_strap,
    input  wire logic [1:0]            reference_sense_strap,
    input  wire logic                  standby_request,
    input  wire logic                  output_enable_n,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic [31:0]                reg_rdata,
    output logic [9:0]                 data_out,
    output logic                       data_out_en,
    output logic                       over_range_flag,
    output logic                       over_range_en,
    output adc_ctrl_pkg::ref_ctrl_t    ref_ctrl,
    output logic                       wake_busy,
    output logic                       irq
);

    localparam int CW = $clog2(WAKE_CYCLES + 1);

    // =================================================================
    // State
    logic [1:0] mode_s1_reg, mode_s2_reg, sense_s1_reg, sense_s2_reg;
    logic [1:0] standby_request_sync_reg, oe_n_sync_reg;
    adc_ctrl_pkg::ref_mode_t  mode_reg,  mode_next;
    adc_ctrl_pkg::ref_ctrl_t  ctrl_reg,  ctrl_next;
    adc_ctrl_pkg::pwr_state_t pwr_reg,   pwr_next;
    logic [CW-1:0]            wake_reg,  wake_next;
    adc_ctrl_pkg::conv_word_t out_reg,   out_next;
    logic                     en_reg,    en_next;
    logic                     soft_standby_request_reg, soft_standby_request_next;
    logic [`IRQ_WIDTH-1:0]    irq_stat_reg,  irq_stat_next;
    logic [`IRQ_WIDTH-1:0]    irq_mask_reg,  irq_mask_next;
    logic                     irq_reg,   irq_next;
    logic [31:0]              rdata_reg, rdata_next;
    logic                     conv_run, standby, wake_done;
    logic [`IRQ_WIDTH-1:0]    events;
    adc_ctrl_pkg::conv_word_t pipe_word;

    // =================================================================
    // Pin synchronisers; only the second stage is read by logic
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_s1_reg   <= 2'h0;
            mode_s2_reg   <= 2'h0;
            sense_s1_reg  <= 2'h3;
            sense_s2_reg  <= 2'h3;
            standby_request_sync_reg <= 2'h0;
            oe_n_sync_reg <= 2'h3;
        end else begin
            mode_s1_reg   <= mode_strap;
            mode_s2_reg   <= mode_s1_reg;
            sense_s1_reg  <= reference_sense_strap;
            sense_s2_reg  <= sense_s1_reg;
            standby_request_sync_reg <= {standby_request_sync_reg[0], standby_request};
            oe_n_sync_reg <= {oe_n_sync_reg[0], output_enable_n};
        end
    end

    // =================================================================
    // Strap decode into switch and buffer settings
    always_comb begin
        ctrl_next = '0;
        // [R7] three-level mode strap
        unique case (mode_s2_reg)
            `STRAP_GROUND:      mode_next = adc_ctrl_pkg::REF_FULL_EXT;
            `STRAP_HALF_SUPPLY: mode_next = adc_ctrl_pkg::REF_DIFF;
            default:            mode_next = adc_ctrl_pkg::REF_TOP_BOTTOM;
        endcase
        // [R9] [R10] [R11] buffer and switch settings
        ctrl_next.buffer_enable     = mode_next != adc_ctrl_pkg::REF_FULL_EXT;
        ctrl_next.buffer_from_sense = mode_next == adc_ctrl_pkg::REF_TOP_BOTTOM;
        ctrl_next.sense_force_join  = mode_next == adc_ctrl_pkg::REF_FULL_EXT;
        // [R12] [R13] generator level, off when strapped to supply
        unique case (sense_s2_reg)
            `SENSE_TO_REF_NODE: ctrl_next.generator_level = adc_ctrl_pkg::GEN_1V;
            `SENSE_TO_GROUND:   ctrl_next.generator_level = adc_ctrl_pkg::GEN_2V;
            `SENSE_TO_DIVIDER:
                ctrl_next.generator_level = adc_ctrl_pkg::GEN_DIVIDER;
            default:            ctrl_next.generator_level = adc_ctrl_pkg::GEN_OFF;
        endcase
        ctrl_next.generator_enable = sense_s2_reg != `SENSE_TO_SUPPLY;
    end

    // =================================================================
    // Power state machine with the wake-up interval
    assign standby = standby_request_sync_reg[1] | soft_standby_request_reg;
    always_comb begin
        pwr_next  = pwr_reg;
        wake_next = wake_reg;
        wake_done = 1'b0;
        unique case (pwr_reg)
            // [R5] standby stops conversion
            adc_ctrl_pkg::PWR_ACTIVE: begin
                if (standby) begin
                    pwr_next = adc_ctrl_pkg::PWR_DOWN;
                end
            end
            adc_ctrl_pkg::PWR_DOWN: begin
                if (!standby) begin
                    pwr_next  = adc_ctrl_pkg::PWR_WAKE;
                    wake_next = CW'(WAKE_CYCLES - 1);
                end
            end
            // [R6] results flagged invalid while waking
            adc_ctrl_pkg::PWR_WAKE: begin
                if (standby) begin
                    pwr_next = adc_ctrl_pkg::PWR_DOWN;
                end else if (wake_reg == '0) begin
                    pwr_next  = adc_ctrl_pkg::PWR_ACTIVE;
                    wake_done = 1'b1;
                end else begin
                    wake_next = wake_reg - 1'b1;
                end
            end
            default: pwr_next = adc_ctrl_pkg::PWR_DOWN;
        endcase
    end

    assign conv_run = pwr_reg != adc_ctrl_pkg::PWR_DOWN;

    // =================================================================
    // Conversion pipeline: sample edge plus two stages
    adc_pipe #(
        .DEPTH        (`PIPE_STAGES)
    ) u_pipe (
        .clock        (clock),
        .reset_n      (reset_n),
        .enable       (conv_run),
        .analog_input (analog_input),
        .result       (pipe_word)
    );

    // Output stage; the enable is the inverse of the synchronised pin
    always_comb begin
        // [R14] [R16] one update per edge, third edge after the sample
        out_next = conv_run ? pipe_word : out_reg;
        // [R1] [R2] data and flag share one enable
        en_next  = !oe_n_sync_reg[1];
    end

    // =================================================================
    // Register port, sticky events and interrupt
    assign events = {mode_next != mode_reg,
                     wake_done,
                     conv_run & out_next.over_range};
    always_comb begin
        soft_standby_request_next = soft_standby_request_reg;
        irq_mask_next  = irq_mask_reg;
        irq_stat_next  = irq_stat_reg;
        rdata_next     = 32'h0000_0000;
        if (reg_write) begin
            unique case (reg_addr)
                `ADDR_CONTROL:    soft_standby_request_next = reg_wdata[`CTRL_SOFT_STANDBY];
                `ADDR_IRQ_STATUS: irq_stat_next  = irq_stat_reg &
                                                   ~reg_wdata[`IRQ_WIDTH-1:0];
                `ADDR_IRQ_MASK:   irq_mask_next  = reg_wdata[`IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
        // Set beats clear so no event is lost on a same-cycle write
        irq_stat_next = irq_stat_next | events;
        if (reg_read) begin
            unique case (reg_addr)
                `ADDR_CONTROL: rdata_next[`CTRL_SOFT_STANDBY] = soft_standby_request_reg;
                `ADDR_STATUS: begin
                    rdata_next[`STAT_MODE_LSB +: 2] = mode_reg;
                    rdata_next[`STAT_GEN_LSB +: 2]  = ctrl_reg.generator_level;
                    rdata_next[`STAT_POWERED_DOWN]  = !conv_run;
                    rdata_next[`STAT_WAKE_BUSY]     = wake_busy;
                end
                `ADDR_IRQ_STATUS: rdata_next[`IRQ_WIDTH-1:0] = irq_stat_reg;
                `ADDR_IRQ_MASK:   rdata_next[`IRQ_WIDTH-1:0] = irq_mask_reg;
                default: ;
            endcase
        end
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // =================================================================
    // All registers of the top level except the pin synchronisers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg      <= adc_ctrl_pkg::REF_FULL_EXT;
            ctrl_reg      <= '{buffer_enable: 1'b0, buffer_from_sense: 1'b0,
                               sense_force_join: 1'b1,
                               generator_enable: 1'b0,
                               generator_level: adc_ctrl_pkg::GEN_OFF};
            pwr_reg       <= adc_ctrl_pkg::PWR_ACTIVE;
            wake_reg      <= '0;
            out_reg       <= '0;
            en_reg        <= 1'b0;
            soft_standby_request_reg <= `CONTROL_RESET;
            irq_stat_reg  <= '0;
            irq_mask_reg  <= `IRQ_MASK_RESET;
            irq_reg       <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            mode_reg      <= mode_next;
            ctrl_reg      <= ctrl_next;
            pwr_reg       <= pwr_next;
            wake_reg      <= wake_next;
            out_reg       <= out_next;
            en_reg        <= en_next;
            soft_standby_request_reg <= soft_standby_request_next;
            irq_stat_reg  <= irq_stat_next;
            irq_mask_reg  <= irq_mask_next;
            irq_reg       <= irq_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign data_out        = out_reg.code;
    assign over_range_flag = out_reg.over_range;
    assign data_out_en     = en_reg;
    assign over_range_en   = en_reg;
    assign ref_ctrl        = ctrl_reg;
    assign reg_rdata       = rdata_reg;
    assign irq             = irq_reg;
    // One-hot wake bit, straight from the state flop
    assign wake_busy       = pwr_reg[2];

    // =================================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence run4_s;
        $past(conv_run) && $past(conv_run, 2) &&
        $past(conv_run, 3) && $past(conv_run, 4);
    endsequence

    pipe_latency_a: assert property (run4_s |-> data_out ==            // [R14]
        adc_ctrl_pkg::convert($past(analog_input, 4)).code)
        else $error("result not three edges after sample");
    code_in_range_a: assert property (run4_s and                       // [R3]
        $past(analog_input, 4) >= 12'sh000 &&
        $past(analog_input, 4) <= 12'sh3FF
        |-> data_out == $past(analog_input[9:0], 4) && !over_range_flag)
        else $error("in-range code not straight binary");
    clamp_flag_a: assert property (run4_s and                          // [R15]
        $past(analog_input, 4) > 12'sh3FF
        |-> data_out == 10'h3FF && over_range_flag)
        else $error("high input not clamped to top code");
    tb_over_range_a: assert property (run4_s and                       // [R4]
        mode_reg == adc_ctrl_pkg::REF_TOP_BOTTOM &&
        $past(analog_input, 4) < 12'sh000
        |-> data_out == 10'h000 && over_range_flag)
        else $error("low input missed over-range");
    standby_hold_a: assert property (                                  // [R5]
        pwr_reg == adc_ctrl_pkg::PWR_DOWN |=> $stable(out_reg))
        else $error("outputs moved in power-down");
    enable_off_a: assert property (output_enable_n [*3]                // [R2]
        |=> !data_out_en && !over_range_en)
        else $error("outputs driven while enable high");
    enable_on_a: assert property ((!output_enable_n && $past(reset_n)) // [R1]
        [*3] |=> data_out_en && over_range_en)
        else $error("outputs not driven while enable low");
    full_ext_a: assert property (mode_reg ==                           // [R9]
        adc_ctrl_pkg::REF_FULL_EXT
        |-> !ref_ctrl.buffer_enable && ref_ctrl.sense_force_join)
        else $error("full external settings wrong");
    diff_mode_a: assert property (mode_reg == adc_ctrl_pkg::REF_DIFF   // [R10]
        |-> ref_ctrl.buffer_enable && !ref_ctrl.buffer_from_sense &&
            !ref_ctrl.sense_force_join)
        else $error("differential settings wrong");
    top_bottom_a: assert property (mode_reg ==                         // [R11]
        adc_ctrl_pkg::REF_TOP_BOTTOM
        |-> ref_ctrl.buffer_enable && ref_ctrl.buffer_from_sense &&
            !ref_ctrl.sense_force_join)
        else $error("top/bottom settings wrong");
    gen_power_a: assert property (                                     // [R13]
        ref_ctrl.generator_enable ==
        (ref_ctrl.generator_level != adc_ctrl_pkg::GEN_OFF))
        else $error("generator power does not match level");
    gen_level_a: assert property (sense_s2_reg ==                      // [R12]
        `SENSE_TO_GROUND |=> ref_ctrl.generator_level ==
        adc_ctrl_pkg::GEN_2V)
        else $error("ground strap did not give 2 V");
    wake_exit_a: assert property (                                     // [R6]
        pwr_reg == adc_ctrl_pkg::PWR_WAKE && wake_reg == '0 && !standby
        |=> pwr_reg == adc_ctrl_pkg::PWR_ACTIVE && irq_stat_reg[1])
        else $error("wake interval did not end");

    wake_seen_c:  cover property (wake_busy ##1 !wake_busy);
    clamp_low_c:  cover property (over_range_flag && data_out == 10'h000);
    irq_raise_c:  cover property (!irq ##1 irq);
    float_out_c:  cover property (data_out_en ##1 !data_out_en);

endmodule

/* tb/host_capture.sv */
// Host-side capture model of the converter output pins
`timescale 1ns/100ps
module host_capture (
    input  wire logic                  clock,
    input  wire logic [9:0]            data_out,
    input  wire logic                  data_out_en,
    input  wire logic                  over_range_flag,
    input  wire logic                  over_range_en,
    input  wire logic                  wake_busy,
    output adc_ctrl_pkg::conv_word_t   cap_word,
    output logic                       cap_valid
);
    logic [9:0] pin_data;
    logic       pin_flag;

    // =================================================================
    // Pin levels
    // Released pins show the inverse of the last word
    assign pin_data = data_out_en ? data_out : ~cap_word.code;
    assign pin_flag = over_range_en ? over_range_flag : ~cap_word.over_range;

    // =================================================================
    // Capture on a fixed rising-edge phase
    // Words during the wake interval are not trusted
    always @(posedge clock) begin
        cap_word  <= '{code: pin_data, over_range: pin_flag};
        cap_valid <= data_out_en & over_range_en & ~wake_busy;
    end
endmodule

/* tb/tb.sv */
// Self-checking bench of the converter output and mode control
`timescale 1ns/100ps
`include "adc_ctrl_defs.svh"
`define CHECK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
    $display("Error at %0t: %s", $time, msg); miscompares++; end end
module tb;
    localparam int WAKE = 20;
    typedef struct { adc_ctrl_pkg::conv_word_t w; int t; } note_t;
    logic clock, reset_n, standby_request, output_enable_n;
    logic reg_write, reg_read, data_out_en, over_range_flag;
    logic over_range_en, wake_busy, irq, cap_valid;
    logic signed [11:0] analog_input;
    logic [1:0] mode_strap, reference_sense_strap;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [9:0] data_out;
    adc_ctrl_pkg::ref_ctrl_t ref_ctrl;
    adc_ctrl_pkg::conv_word_t cap_word;
    note_t q[$];
    note_t n;
    int cyc, miscompares, cmp_count, k, c;
    int edge_vals[6] = '{-1, 0, 1, 1023, 1024, -100};

    adc_output_and_mode_control #(.WAKE_CYCLES(WAKE))
        adc_output_and_mode_control_inst (.clock(clock), .reset_n(reset_n),
        .analog_input(analog_input), .mode_strap(mode_strap),
        .reference_sense_strap(reference_sense_strap),
        .standby_request(standby_request), .output_enable_n(output_enable_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .data_out(data_out),
        .data_out_en(data_out_en), .over_range_flag(over_range_flag),
        .over_range_en(over_range_en), .ref_ctrl(ref_ctrl),
        .wake_busy(wake_busy), .irq(irq));
    host_capture host_capture_inst (.clock(clock), .data_out(data_out),
        .data_out_en(data_out_en), .over_range_flag(over_range_flag),
        .over_range_en(over_range_en), .wake_busy(wake_busy),
        .cap_word(cap_word), .cap_valid(cap_valid));

    // =================================================================
    // Expected values
    function automatic adc_ctrl_pkg::conv_word_t ideal_word(input int v);
        ideal_word.over_range = (v < 0) || (v > 1023);
        ideal_word.code = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
    endfunction
    function automatic adc_ctrl_pkg::ref_ctrl_t ideal_ref(input int m, s);
        ideal_ref = '{buffer_enable: m != 0, buffer_from_sense: m >= 2,
            sense_force_join: m == 0, generator_enable: s != 3,
            generator_level: adc_ctrl_pkg::gen_level_t'(s[1:0])};
    endfunction

    // =================================================================
    // Drivers; every sample is noted with its launch cycle
    // Only single-ended levels are driven
    task automatic drive_sample(input int v);
        @(posedge clock);
        analog_input <= 12'(v);
        q.push_back('{w: ideal_word(v), t: cyc});
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHECK(reg_rdata & m, e, "register read")
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // =================================================================
    // Watcher: a word sampled after launch edge P is captured at P+5
    always @(negedge clock) begin
        if (q.size() > 0 && q[0].t + 5 == cyc) begin
            n = q.pop_front();
            `CHECK({cap_valid, cap_word}, {1'b1, n.w}, "result word")
        end
        cyc++;
    end

    // Clock and watchdog; the run needs well under 3000 cycles
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end

    // =================================================================
    // Main sequence
    initial begin
        {reset_n, standby_request, output_enable_n, reg_write} = 4'h0;
        {reg_read, reg_addr, reg_wdata, analog_input} = '0;
        mode_strap = 2'h2;
        reference_sense_strap = 2'h3;
        void'($urandom(84890));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        reg_rd(`ADDR_CONTROL, 32'h1, 32'h0);
        reg_rd(`ADDR_IRQ_MASK, 32'h7, 32'h0);
        reg_rd(8'h10, 32'hFFFFFFFF, 32'h0);
        // Boundary codes, then random levels straddling full scale
        foreach (edge_vals[i]) drive_sample(edge_vals[i]);
        repeat (60) drive_sample(int'($urandom_range(1223)) - 100);
        repeat (8) @(posedge clock);
        $display("Test stream done");
        // Every strap pair; switches settle three edges after a change
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clock);
                mode_strap <= m[1:0];
                reference_sense_strap <= s[1:0];
                repeat (5) @(posedge clock);
                #1;
                `CHECK(ref_ctrl, ideal_ref(m, s), "switches")
                reg_rd(`ADDR_STATUS, 32'hF,
                       {s[1:0], (m > 1) ? 2'h2 : m[1:0]});
            end
        end
        $display("Test straps done");
        // Over-range event: masked, unmasked, cleared
        // In-range level first, so an old flag cannot re-set the bit
        drive_sample(100);
        mode_strap <= 2'h2;
        repeat (4) @(posedge clock);
        reg_wr(`ADDR_IRQ_STATUS, 32'h7);
        reg_rd(`ADDR_IRQ_STATUS, 32'h1, 32'h0);
        drive_sample(2000);
        repeat (8) drive_sample(int'($urandom_range(1023)));
        reg_rd(`ADDR_IRQ_STATUS, 32'h1, 32'h1);
        `CHECK(irq, 1'b0, "masked irq")
        reg_wr(`ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clock);
        `CHECK(irq, 1'b1, "irq raised")
        reg_wr(`ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge clock);
        `CHECK(irq, 1'b0, "irq cleared")
        $display("Test interrupt done");
        // Output enable floats data and flag together
        @(posedge clock);
        output_enable_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        `CHECK({data_out_en, over_range_en}, 2'h0, "outputs off")
        output_enable_n <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        `CHECK({data_out_en, over_range_en}, 2'h3, "outputs on")
        $display("Test enable done");
        // Standby freezes the output, then a counted wake interval
        drive_sample(500);
        repeat (6) @(posedge clock);
        standby_request <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        repeat (10) begin
            @(posedge clock);
            analog_input <= 12'($urandom_range(1023));
        end
        // The last level before power-down stays on the pins
        `CHECK(data_out, 10'h1F4, "frozen output")
        reg_rd(`ADDR_STATUS, 32'h10, 32'h10);
        // Soft standby keeps the converter down once the pin is low
        reg_wr(`ADDR_CONTROL, 32'h1);
        standby_request <= 1'b0;
        repeat (4) @(posedge clock);
        reg_rd(`ADDR_STATUS, 32'h30, 32'h10);
        reg_wr(`ADDR_CONTROL, 32'h0);
        k = 0;
        while (wake_busy !== 1'b1 && k < 10) begin
            @(posedge clock);
            #1;
            k++;
        end
        c = 0;
        while (wake_busy === 1'b1 && c < 200) begin
            c++;
            @(posedge clock);
            #1;
        end
        `CHECK(c, WAKE, "wake length")
        reg_rd(`ADDR_IRQ_STATUS, 32'h2, 32'h2);
        repeat (20) drive_sample(int'($urandom_range(1223)) - 100);
        repeat (8) @(posedge clock);
        $display("Test standby done");
        close_out();
    end
endmodule
